//--- hdl/phy_pkg.sv
// Purpose: Shared constants for the transceiver timing block
// Assumes: Core clock 20 MHz; link clock 100 MHz (twice the 50 MHz ref)
// Notes:   Times kept in their own unit, cycle counts derived from them
package phy_pkg;
   // -------------------------------------------------------------
   // Clock rates
   // -------------------------------------------------------------
   localparam int CORE_NS = 50;
   localparam int CORE_PER_US = 20;
   localparam int LINK_NS = 10;
   // -------------------------------------------------------------
   // Start-up timing
   // -------------------------------------------------------------
   localparam int STRAP_LATCH_NS = 120;
   localparam int PIN_DRIVE_NS = 64;
   localparam int MGMT_WAIT_MS = 2;
   localparam int FLP_DELAY_MS = 1500;
   localparam int STRAP_CYC = (STRAP_LATCH_NS + CORE_NS - 1) / CORE_NS;
   localparam int DRIVE_CYC = (PIN_DRIVE_NS + CORE_NS - 1) / CORE_NS;
   localparam int MGMT_CYC = MGMT_WAIT_MS * 1000 * CORE_PER_US;
   localparam int FLP_DELAY_CYC = FLP_DELAY_MS * 1000 * CORE_PER_US;
   // -------------------------------------------------------------
   // Link pulses and jabber
   // -------------------------------------------------------------
   localparam int NLP_PERIOD_MS = 16;
   localparam int NLP_WIDTH_NS = 100;
   localparam int FLP_CLK_US = 125;
   localparam int FLP_DATA_US = 62;
   localparam int FLP_WIDTH_NS = 114;
   localparam int FLP_BURST_MS = 2;
   localparam int JAB_ON_MS = 100;
   localparam int JAB_OFF_MS = 500;
   localparam int PERIOD_CYC = NLP_PERIOD_MS * 1000 * CORE_PER_US;
   localparam int NLP_W_CYC = (NLP_WIDTH_NS + CORE_NS - 1) / CORE_NS;
   localparam int FLP_SLOT_CYC = FLP_CLK_US * CORE_PER_US;
   localparam int FLP_DATA_CYC = FLP_DATA_US * CORE_PER_US;
   localparam int FLP_W_CYC = (FLP_WIDTH_NS + CORE_NS - 1) / CORE_NS;
   localparam int BURST_CYC = FLP_BURST_MS * 1000 * CORE_PER_US;
   localparam int JAB_ON_CYC = JAB_ON_MS * 1000 * CORE_PER_US;
   localparam int JAB_OFF_CYC = JAB_OFF_MS * 1000 * CORE_PER_US;
   localparam logic [3:0] FLP_LAST_SLOT = 4'hF;
   // -------------------------------------------------------------
   // MAC interface clocks, in link cycles
   // -------------------------------------------------------------
   localparam int MII_HALF_100_NS = 20;
   localparam int MII_HALF_10_NS = 200;
   localparam int RMII_CYC_NS = 20;
   localparam int RGMII_CYC_100_NS = 40;
   localparam int RGMII_CYC_10_NS = 400;
   localparam logic [4:0] HALF_MII_100 = 5'(MII_HALF_100_NS / LINK_NS);
   localparam logic [4:0] HALF_MII_10 = 5'(MII_HALF_10_NS / LINK_NS);
   localparam logic [4:0] HALF_RMII = 5'(RMII_CYC_NS / 2 / LINK_NS);
   localparam logic [4:0] HALF_RGMII_100 = 5'(RGMII_CYC_100_NS / 2 / LINK_NS);
   localparam logic [4:0] HALF_RGMII_10 = 5'(RGMII_CYC_10_NS / 2 / LINK_NS);
   localparam logic [1:0] MODE_MII = 2'h0;
   localparam logic [1:0] MODE_RMII = 2'h1;
   localparam logic [1:0] MODE_RGMII = 2'h2;
   localparam logic [15:0] RMII_RXCLK_ADDR = 16'h000A;
   // -------------------------------------------------------------
   // Line latency
   // -------------------------------------------------------------
   localparam int TX_LAT_NS = 48;
   localparam int RX_LAT_MAX_NS = 218;
   localparam int TX_LAT_CYC = (TX_LAT_NS + LINK_NS - 1) / LINK_NS;
   localparam int SYNC_CYC = 2;
   localparam logic [4:0] RX_DV_CYC =
      5'((RX_LAT_MAX_NS - 2 * MII_HALF_100_NS) / LINK_NS + 1 - SYNC_CYC);
endpackage

//--- hdl/phy_sync2.sv
// Purpose: Two-flop level synchroniser
// Assumes: Input is a slowly changing level
// Notes:   First stage is read only by the second
`timescale 1ns/1ps
module phy_sync2 #(
   parameter int W = 1
) (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] meta_q;

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         meta_q <= '0;
         q_o <= '0;
      end else begin
         meta_q <= d_i;
         q_o <= meta_q;
      end
   end
endmodule

//--- hdl/phy_tick.sv
// Purpose: Wrapping cycle counter with a terminal-count flag
// Assumes: limit_i is at least one
// Notes:   Clear has priority over counting
`timescale 1ns/1ps
module phy_tick (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic clear_i,
   input wire logic en_i,
   input wire logic [31:0] limit_i,
   output logic [31:0] count_o,
   output logic hit_o
);
   assign hit_o = en_i && (count_o == limit_i - 32'h1);

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         count_o <= 32'h0;
      end else if (clear_i || hit_o) begin
         count_o <= 32'h0;
      end else if (en_i) begin
         count_o <= count_o + 32'h1;
      end
   end
endmodule

//--- hdl/phy_timing.sv
// Purpose: Reset sequencing, link pulses, jabber and MAC-side clocking
// Assumes: link_clk_i is twice the 50 MHz ref clock; MAC launches
//          transmit data on the clocks this block drives
// Notes:   Long counts are parameters so simulation can shorten them
//
// Overview of operation
// RULE_01: Controller holds reset low 10 us with ref clock stable 1 us.
// RULE_02: Management master waits up to 2 ms, then 32-bit preamble.
// RULE_03: Strap pins captured about 120 ns after reset release.
// RULE_04: Strap pins become driven outputs about 64 ns after capture.
// RULE_05: Fast link pulse bursts start about 1.5 s after reset release.
// RULE_06: MII transmit clock high/low 20 ns at 100M, 200 ns at 10M.
// RULE_07: MII receive outputs launched 10-30 ns (100M) after receive clock rise.
// RULE_08: RMII transmit data and enable sampled on 20 ns clock rise.
// RULE_09: RMII master mode drives 20 ns clock on receive data bit 3.
// RULE_10: RMII receive-clock mode drives 20 ns receive clock.
// RULE_11: RGMII clock period 40 ns at 100M, 400 ns at 10M.
// RULE_12: RGMII duty 40-60%, stretch at most three slow cycles.
// RULE_13: RGMII works with or without integrated clock-to-data delay.
// RULE_14: Normal link pulses about 100 ns wide every 16 ms.
// RULE_15: FLP clock pulses 125 us apart, data at 62 us, 114 ns wide.
// RULE_16: FLP bursts repeat every 16 ms and last about 2 ms.
// RULE_17: 10M jabber on after 100 ms transmit, off 500 ms later.
// RULE_18: Line /J/ starts 48 ns typical after sampling transmit edge.
// RULE_19: Receive valid on receive clock rise within 218 ns of /J/.
// RULE_20: Line transmit blocked while jabber is active.
`timescale 1ns/1ps
module phy_timing import phy_pkg::*; #(
   parameter int MGMT_WAIT = MGMT_CYC,
   parameter int FLP_DELAY = FLP_DELAY_CYC,
   parameter int PERIOD = PERIOD_CYC,
   parameter int BURST = BURST_CYC,
   parameter int JAB_ON = JAB_ON_CYC,
   parameter int JAB_OFF = JAB_OFF_CYC
) (
   input wire logic core_clk_i,
   input wire logic reset_n_i,
   input wire logic link_clk_i,
   input wire logic [3:0] strap_i,
   output logic [3:0] strap_o,
   output logic [3:0] strap_oe_o,
   input wire logic [1:0] mode_i,
   input wire logic speed100_i,
   input wire logic rgmii_delay_i,
   input wire logic rmii_master_i,
   input wire logic rmii_rxclk_i,
   input wire logic [15:0] flp_word_i,
   output logic mgmt_ready_o,
   output logic link_pulse_o,
   output logic jabber_o,
   input wire logic [3:0] tx_d_i,
   input wire logic tx_en_i,
   output logic tx_clk_o,
   output logic rx_clk_o,
   output logic [3:0] rx_d_o,
   output logic rx_dv_o,
   output logic rx_er_o,
   input wire logic [3:0] line_rx_d_i,
   input wire logic line_rx_act_i,
   input wire logic line_rx_er_i,
   output logic [3:0] line_tx_d_o,
   output logic line_tx_en_o
);
   localparam int TXL = TX_LAT_CYC;

   typedef enum logic [3:0] {
      ST_LATCH = 4'h1,
      ST_DRIVE = 4'h2,
      ST_WAIT = 4'h4,
      ST_RUN = 4'h8
   } phy_boot_e;

   typedef enum logic [2:0] {
      JB_IDLE = 3'h1,
      JB_COUNT = 3'h2,
      JB_ACTIVE = 3'h4
   } phy_jab_e;

   // -------------------------------------------------------------
   // Core-domain pin synchronisers
   // -------------------------------------------------------------
   logic [3:0] strap_s;
   logic [1:0] core_s;
   logic speed100_c;
   logic tx_act_c;

   phy_sync2 #(.W(4)) u_sync_strap (
      .clk_i(core_clk_i),
      .reset_n_i(reset_n_i),
      .d_i(strap_i),
      .q_o(strap_s)
   );

   phy_sync2 #(.W(2)) u_sync_core (
      .clk_i(core_clk_i),
      .reset_n_i(reset_n_i),
      .d_i({speed100_i, line_tx_en_o}),
      .q_o(core_s)
   );

   assign speed100_c = core_s[1];
   assign tx_act_c = core_s[0];

   // -------------------------------------------------------------
   // Start-up sequence
   // -------------------------------------------------------------
   phy_boot_e boot_q;
   logic [31:0] elapsed_q;
   logic [3:0] strap_cfg_q;
   logic run_q;

   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         elapsed_q <= 32'h0;
      end else if (elapsed_q != 32'(FLP_DELAY)) begin
         elapsed_q <= elapsed_q + 32'h1;
      end
   end

   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         boot_q <= ST_LATCH;
         strap_cfg_q <= 4'h0;
         strap_oe_o <= 4'h0;
         mgmt_ready_o <= 1'b0;
         run_q <= 1'b0;
      end else begin
         case (boot_q)
            ST_LATCH: begin
               // RULE_03: capture straps
               if (elapsed_q == 32'(STRAP_CYC - 1)) begin
                  strap_cfg_q <= strap_s;
                  boot_q <= ST_DRIVE;
               end
            end
            ST_DRIVE: begin
               // RULE_04: pins turn to outputs
               if (elapsed_q == 32'(STRAP_CYC + DRIVE_CYC - 1)) begin
                  strap_oe_o <= 4'hF;
                  boot_q <= ST_WAIT;
               end
            end
            ST_WAIT: begin
               // RULE_02: management access window
               if (elapsed_q >= 32'(MGMT_WAIT - 1)) begin
                  mgmt_ready_o <= 1'b1;
               end
               // RULE_05: pulses start after delay
               if (elapsed_q == 32'(FLP_DELAY - 1)) begin
                  run_q <= 1'b1;
                  boot_q <= ST_RUN;
               end
            end
            ST_RUN: begin
               mgmt_ready_o <= 1'b1;
            end
            default: begin
               boot_q <= ST_LATCH;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         strap_o <= 4'h0;
      end else begin
         strap_o <= {jabber_o, link_pulse_o, mgmt_ready_o, run_q};
      end
   end

   // -------------------------------------------------------------
   // Link pulses: NLP when straps disable negotiation, else FLP
   // -------------------------------------------------------------
   logic an_en;
   logic [31:0] per_cnt;
   logic [31:0] slot_cnt;
   logic slot_hit;
   logic in_burst;
   logic [3:0] slot_idx_q;
   logic pulse_d;

   assign an_en = strap_cfg_q[0];

   // RULE_14: 16 ms period
   // RULE_16: burst repeat period
   phy_tick u_period (
      .clk_i(core_clk_i),
      .reset_n_i(reset_n_i),
      .clear_i(!run_q),
      .en_i(run_q),
      .limit_i(32'(PERIOD)),
      .count_o(per_cnt),
      .hit_o()
   );

   // RULE_16: burst lasts 2 ms
   assign in_burst = run_q && an_en && (per_cnt < 32'(BURST));

   // RULE_15: 125 us pulse slots
   phy_tick u_slot (
      .clk_i(core_clk_i),
      .reset_n_i(reset_n_i),
      .clear_i(!in_burst),
      .en_i(in_burst),
      .limit_i(32'(FLP_SLOT_CYC)),
      .count_o(slot_cnt),
      .hit_o(slot_hit)
   );

   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         slot_idx_q <= 4'h0;
      end else if (!in_burst) begin
         slot_idx_q <= 4'h0;
      end else if (slot_hit && slot_idx_q != FLP_LAST_SLOT) begin
         slot_idx_q <= slot_idx_q + 4'h1;
      end
   end

   always_comb begin
      pulse_d = 1'b0;
      if (run_q && !an_en) begin
         // RULE_14: 100 ns wide NLP
         pulse_d = per_cnt < 32'(NLP_W_CYC);
      end else if (in_burst) begin
         // RULE_15: clock pulse then data pulse
         pulse_d = (slot_cnt < 32'(FLP_W_CYC)) ||
            (flp_word_i[slot_idx_q] &&
             slot_cnt >= 32'(FLP_DATA_CYC) &&
             slot_cnt < 32'(FLP_DATA_CYC + FLP_W_CYC));
      end
   end

   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         link_pulse_o <= 1'b0;
      end else begin
         link_pulse_o <= pulse_d;
      end
   end

   // -------------------------------------------------------------
   // Jabber (10 Mbps only)
   // -------------------------------------------------------------
   phy_jab_e jab_q;
   logic [31:0] jab_cnt;
   logic jab_hit;
   logic [31:0] jab_lim;

   assign jab_lim = (jab_q == JB_ACTIVE) ? 32'(JAB_OFF) : 32'(JAB_ON);

   phy_tick u_jab (
      .clk_i(core_clk_i),
      .reset_n_i(reset_n_i),
      .clear_i(jab_q == JB_IDLE),
      .en_i(jab_q != JB_IDLE),
      .limit_i(jab_lim),
      .count_o(jab_cnt),
      .hit_o(jab_hit)
   );

   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         jab_q <= JB_IDLE;
         jabber_o <= 1'b0;
      end else begin
         case (jab_q)
            JB_IDLE: begin
               if (tx_act_c && !speed100_c) begin
                  jab_q <= JB_COUNT;
               end
            end
            JB_COUNT: begin
               // RULE_17: activate after continuous transmit
               if (!tx_act_c || speed100_c) begin
                  jab_q <= JB_IDLE;
               end else if (jab_hit) begin
                  jab_q <= JB_ACTIVE;
                  jabber_o <= 1'b1;
               end
            end
            JB_ACTIVE: begin
               // RULE_17: release after deactivation time
               if (jab_hit) begin
                  jab_q <= JB_IDLE;
                  jabber_o <= 1'b0;
               end
            end
            default: begin
               jab_q <= JB_IDLE;
               jabber_o <= 1'b0;
            end
         endcase
      end
   end

   // -------------------------------------------------------------
   // Link-domain synchronisers
   // -------------------------------------------------------------
   logic [11:0] lk_s;
   logic [1:0] mode_l;
   logic speed_l;
   logic delay_l;
   logic master_l;
   logic rxclk_l;
   logic jab_l;
   logic act_l;
   logic er_l;
   logic [3:0] rxd_l;

   phy_sync2 #(.W(12)) u_sync_link (
      .clk_i(link_clk_i),
      .reset_n_i(reset_n_i),
      .d_i({mode_i, speed100_i, rgmii_delay_i, rmii_master_i,
            rmii_rxclk_i, jabber_o, line_rx_act_i, line_rx_er_i,
            line_rx_d_i[2:0]}),
      .q_o(lk_s)
   );

   phy_sync2 #(.W(1)) u_sync_d3 (
      .clk_i(link_clk_i),
      .reset_n_i(reset_n_i),
      .d_i(line_rx_d_i[3]),
      .q_o(rxd_l[3])
   );

   assign mode_l = lk_s[11:10];
   assign speed_l = lk_s[9];
   assign delay_l = lk_s[8];
   assign master_l = lk_s[7];
   assign rxclk_l = lk_s[6];
   assign jab_l = lk_s[5];
   assign act_l = lk_s[4];
   assign er_l = lk_s[3];
   assign rxd_l[2:0] = lk_s[2:0];

   // -------------------------------------------------------------
   // MAC interface clock generator
   // -------------------------------------------------------------
   logic [4:0] half_sel;
   logic [4:0] half_cnt_q;
   logic gclk_q;
   logic gclk_d;
   logic rise;
   logic fall;
   logic launch;

   always_comb begin
      case (mode_l)
         // RULE_06: MII half periods
         MODE_MII: half_sel = speed_l ? HALF_MII_100 : HALF_MII_10;
         // RULE_08: 20 ns RMII clock
         MODE_RMII: half_sel = HALF_RMII;
         // RULE_11: RGMII cycle per speed
         MODE_RGMII: half_sel = speed_l ? HALF_RGMII_100 : HALF_RGMII_10;
         default: half_sel = HALF_MII_100;
      endcase
   end

   // RULE_12: new speed applies at once to the phase in progress
   assign gclk_d = (half_cnt_q >= half_sel - 5'h1) ? !gclk_q : gclk_q;
   assign rise = gclk_d && !gclk_q;
   assign fall = !gclk_d && gclk_q;
   // RULE_13: data centred with delay, edge-aligned without
   assign launch = (mode_l == MODE_RGMII && !delay_l) ? rise : fall;

   always_ff @(posedge link_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         half_cnt_q <= 5'h0;
         gclk_q <= 1'b0;
      end else begin
         gclk_q <= gclk_d;
         half_cnt_q <= (gclk_d != gclk_q) ? 5'h0 : half_cnt_q + 5'h1;
      end
   end

   always_ff @(posedge link_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         tx_clk_o <= 1'b0;
         rx_clk_o <= 1'b0;
      end else begin
         // RULE_06: MII transmit clock
         tx_clk_o <= (mode_l != MODE_RMII) && gclk_d;
         // RULE_10: receive clock in RMII only on request
         rx_clk_o <= (mode_l != MODE_RMII || rxclk_l) && gclk_d;
      end
   end

   // -------------------------------------------------------------
   // Transmit path
   // -------------------------------------------------------------
   logic [4:0] tx_pipe_q [TX_LAT_CYC];

   always_ff @(posedge link_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         for (int i = 0; i < TX_LAT_CYC; i++) begin
            tx_pipe_q[i] <= 5'h0;
         end
      end else begin
         // RULE_08: sample on clock rise
         if (rise) begin
            tx_pipe_q[0] <= {tx_en_i, tx_d_i};
         end
         for (int i = 1; i < TX_LAT_CYC; i++) begin
            tx_pipe_q[i] <= tx_pipe_q[i-1];
         end
      end
   end

   always_ff @(posedge link_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         line_tx_en_o <= 1'b0;
         line_tx_d_o <= 4'h0;
      end else begin
         // RULE_18: fixed line latency
         // RULE_20: jabber blocks the line
         line_tx_en_o <= tx_pipe_q[TX_LAT_CYC-1][4] && !jab_l;
         line_tx_d_o <= jab_l ? 4'h0 : tx_pipe_q[TX_LAT_CYC-1][3:0];
      end
   end

   // -------------------------------------------------------------
   // Receive path
   // -------------------------------------------------------------
   logic act_q;
   logic [4:0] rx_wait_q;
   logic rx_arm;

   assign rx_arm = act_l && (rx_wait_q >= RX_DV_CYC);

   always_ff @(posedge link_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         act_q <= 1'b0;
         rx_wait_q <= 5'h0;
      end else begin
         act_q <= act_l;
         if (act_l && !act_q) begin
            rx_wait_q <= 5'h0;
         end else if (act_l && rx_wait_q != RX_DV_CYC) begin
            rx_wait_q <= rx_wait_q + 5'h1;
         end
      end
   end

   always_ff @(posedge link_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rx_dv_o <= 1'b0;
         rx_er_o <= 1'b0;
         rx_d_o <= 4'h0;
      end else begin
         // RULE_07: launch after clock rise
         // RULE_19: valid bounded after /J/
         if (launch) begin
            rx_dv_o <= rx_arm;
            rx_er_o <= rx_arm && er_l;
            rx_d_o[2:0] <= rx_arm ? rxd_l[2:0] : 3'h0;
         end
         // RULE_09: master clock on data bit 3
         if (mode_l == MODE_RMII && master_l) begin
            rx_d_o[3] <= gclk_d;
         end else if (launch) begin
            rx_d_o[3] <= rx_arm && rxd_l[3];
         end
      end
   end

   // -------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------
   property p_strap;
      @(posedge core_clk_i) disable iff (!reset_n_i)
      $changed(boot_q) && boot_q == ST_DRIVE |->
         elapsed_q == 32'(STRAP_CYC);
   endproperty
   a_strap: assert property (p_strap) // RULE_03
      else $error("Straps captured at the wrong time");

   property p_drive;
      @(posedge core_clk_i) disable iff (!reset_n_i)
      $rose(strap_oe_o[0]) |-> elapsed_q == 32'(STRAP_CYC + DRIVE_CYC);
   endproperty
   a_drive: assert property (p_drive) // RULE_04
      else $error("Strap pins driven at the wrong time");

   property p_run;
      @(posedge core_clk_i) disable iff (!reset_n_i)
      $rose(run_q) |-> elapsed_q == 32'(FLP_DELAY) && mgmt_ready_o;
   endproperty
   a_run: assert property (p_run) // RULE_05
      else $error("Link pulses started at the wrong time");

   property p_nlp;
      @(posedge core_clk_i) disable iff (!reset_n_i)
      $rose(link_pulse_o) && !an_en |-> link_pulse_o [*2] ##1 !link_pulse_o;
   endproperty
   a_nlp: assert property (p_nlp) // RULE_14
      else $error("Normal link pulse width wrong");

   property p_flp;
      @(posedge core_clk_i) disable iff (!reset_n_i)
      $rose(link_pulse_o) && an_en |-> link_pulse_o [*3] ##1 !link_pulse_o;
   endproperty
   a_flp: assert property (p_flp) // RULE_15
      else $error("Fast link pulse width wrong");

   property p_jab_off;
      @(posedge core_clk_i) disable iff (!reset_n_i)
      $fell(jabber_o) |-> $past(jab_cnt) == 32'(JAB_OFF - 1);
   endproperty
   a_jab_off: assert property (p_jab_off) // RULE_17
      else $error("Jabber released early or late");

   property p_jab_block;
      @(posedge link_clk_i) disable iff (!reset_n_i)
      jab_l |=> !line_tx_en_o && line_tx_d_o == 4'h0;
   endproperty
   a_jab_block: assert property (p_jab_block) // RULE_20
      else $error("Line driven while jabber active");

   property p_tx_lat;
      @(posedge link_clk_i) disable iff (!reset_n_i)
      rise && tx_en_i ##0 !jab_l [*1] ##TXL !jab_l |=> line_tx_en_o;
   endproperty
   a_tx_lat: assert property (p_tx_lat) // RULE_18
      else $error("Transmit latency wrong");

   property p_half;
      @(posedge link_clk_i) disable iff (!reset_n_i)
      $changed(gclk_q) |-> $past(half_cnt_q) <= HALF_MII_10 - 5'h1;
   endproperty
   a_half: assert property (p_half) // RULE_12
      else $error("Interface clock phase stretched");
endmodule

//--- tb/phy_mac_model.sv
// Purpose: MAC transmit side model
// Assumes: MAC launches just after the PHY transmit clock rises
// Notes:   Idle data is the previous nibble inverted, so it toggles each clock
`timescale 1ns/1ps
module phy_mac_model (
   input wire logic tx_clk_i,
   input wire logic send_i,
   output logic tx_en_o,
   output logic [3:0] tx_d_o
);
   initial begin
      tx_en_o = 1'b0;
      tx_d_o = 4'h0;
   end
   always @(posedge tx_clk_i) begin
      tx_en_o <= send_i;
      tx_d_o <= send_i ? tx_d_o + 4'h1 : ~tx_d_o;
   end
endmodule

//--- tb/tb_phy_timing.sv
// Purpose: Self-checking bench for the transceiver timing block
// Assumes: Shortened counts; link clock 48 ns, offset from core clock
// Notes:   Line transmit is looped back to line receive
`timescale 1ns/1ps
module tb_phy_timing import phy_pkg::*;;
   logic core_clk = 1'b0, link_clk = 1'b0, reset_n = 1'b0, send = 1'b0;
   logic speed100 = 1'b1, tx_en, tx_clk, pulse, jabber, mgmt, rx_dv, ltx_en;
   logic [3:0] strap = 4'h0, tx_d, strap_oe, ltx_d;
   logic [3:0] strap_q, rx_d;
   logic [1:0] mode = MODE_MII;
   logic rdly = 1'b0, rmst = 1'b0, rrxc = 1'b0, rxer = 1'b0, rx_clk, rx_er;
   logic [15:0] flp_word = 16'h0000;
   int error_cnt = 0, tests_run = 0, cyc = 0, hi, per;
   always #25 core_clk = ~core_clk;
   initial begin
      #7;
      forever #24 link_clk = ~link_clk;
   end
   phy_timing #(.MGMT_WAIT(20), .FLP_DELAY(200), .PERIOD(6000),
      .BURST(5000), .JAB_ON(100), .JAB_OFF(300)) i_phy_timing (
      .core_clk_i(core_clk), .reset_n_i(reset_n), .link_clk_i(link_clk),
      .strap_i(strap), .strap_o(strap_q), .strap_oe_o(strap_oe),
      .mode_i(mode), .speed100_i(speed100), .rgmii_delay_i(rdly),
      .rmii_master_i(rmst), .rmii_rxclk_i(rrxc), .flp_word_i(flp_word),
      .mgmt_ready_o(mgmt), .link_pulse_o(pulse), .jabber_o(jabber),
      .tx_d_i(tx_d), .tx_en_i(tx_en), .tx_clk_o(tx_clk), .rx_clk_o(rx_clk),
      .rx_d_o(rx_d), .rx_dv_o(rx_dv), .rx_er_o(rx_er), .line_rx_d_i(ltx_d),
      .line_rx_act_i(ltx_en), .line_rx_er_i(rxer),
      .line_tx_d_o(ltx_d), .line_tx_en_o(ltx_en));
   phy_mac_model i_phy_mac_model (.tx_clk_i(tx_clk), .send_i(send),
      .tx_en_o(tx_en), .tx_d_o(tx_d));
   // ---------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------
   task automatic conclude;
      $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wait_core(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic rst;
      @(posedge core_clk);
      reset_n <= 1'b0;
      wait_core(10 * CORE_PER_US);
      @(posedge core_clk);
      reset_n <= 1'b1;
   endtask
   // Pulse width, then cycles from its rise to the next rise
   task automatic meas;
      per = 0;
      hi = 0;
      while (pulse !== 1'b1 && per < 20000) begin wait_core(1); per++; end
      while (pulse === 1'b1 && hi < 20000) begin wait_core(1); hi++; end
      per = hi;
      while (pulse !== 1'b1 && per < 20000) begin wait_core(1); per++; end
   endtask
   task automatic clk_half(input logic [4:0] half);
      realtime t;
      @(posedge tx_clk);
      t = $realtime;
      @(negedge tx_clk);
      chk(32'(int'($realtime - t)), 32'(half) * 48);
   endtask
   // ---------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------
   task automatic t_startup;
      rst();
      wait_core(4);
      chk(32'(strap_oe), 32'h0);
      wait_core(1);
      chk(32'(strap_oe), 32'hF);
      wait_core(14);
      chk(32'(mgmt), 32'h0);
      wait_core(1);
      chk(32'(mgmt), 32'h1);
      $display("startup done");
   endtask
   task automatic t_nlp;
      meas();
      chk(32'(hi), 32'(NLP_W_CYC));
      chk(32'(per), 32'h1770);
      $display("normal pulses done");
   endtask
   task automatic t_clocks;
      clk_half(HALF_MII_100);
      speed100 <= 1'b0;
      wait_core(4);
      clk_half(HALF_MII_10);
      $display("clocks done");
   endtask
   task automatic t_jabber;
      send <= 1'b1;
      wait_core(130);
      chk(32'(ltx_en), 32'h1);
      chk(32'(rx_dv), 32'h1);
      chk(32'(rx_er), 32'h0);
      per = 0;
      while (jabber !== 1'b1 && per < 400) begin wait_core(1); per++; end
      wait_core(4);
      chk(32'(ltx_en), 32'h0);
      hi = 4;
      while (jabber === 1'b1 && hi < 1000) begin wait_core(1); hi++; end
      chk(32'(hi), 32'h12C);
      send <= 1'b0;
      wait_core(40);
      $display("jabber done");
   endtask
   task automatic t_rmii;
      realtime t;
      mode <= MODE_RMII;
      rmst <= 1'b1;
      rrxc <= 1'b1;
      wait_core(4);
      @(posedge rx_clk);
      t = $realtime;
      #1;
      chk(32'(rx_d[3]), 32'h1);
      @(negedge rx_clk);
      chk(32'(int'($realtime - t)), 32'(HALF_RMII) * 48);
      chk(32'(tx_clk), 32'h0);
      $display("rmii done");
   endtask
   task automatic t_flp;
      strap <= 4'h1;
      flp_word <= 16'hFFFF;
      rst();
      meas();
      chk(32'(hi), 32'(FLP_W_CYC));
      chk(32'(per), 32'(FLP_DATA_CYC));
      meas();
      chk(32'(per), 32'(FLP_SLOT_CYC - FLP_DATA_CYC));
      $display("fast pulses done");
   endtask
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 60000) begin
         error_cnt++;
         conclude();
      end
   end
   initial begin
      t_startup();
      t_nlp();
      t_clocks();
      t_jabber();
      t_rmii();
      t_flp();
      conclude();
   end
endmodule
